// [design/lsc_pkg.sv]
// Shared constants for the supply control slave: bus address, register
// layout, reset values, limiter timing and state encodings.
// Assumes a 10 MHz system clock; timing counts are derived from it here.
package lsc_pkg;

   // Bus address with the address pin at its lowest level; the pin code adds on
   localparam logic [6:0] LSC_ADDR_BASE     = 7'h08;
   localparam logic [3:0] LSC_BITS_PER_BYTE = 4'h8;

   // Register layout, most significant bit first
   localparam int LSC_REG_LIMITER  = 7;
   localparam int LSC_REG_TXSEL    = 6;
   localparam int LSC_REG_TONE     = 5;
   localparam int LSC_REG_BOOST    = 4;
   localparam int LSC_REG_LEVEL    = 3;
   localparam int LSC_REG_ENABLE   = 2;
   localparam int LSC_REG_OTF      = 1;
   localparam int LSC_REG_OLF      = 0;
   localparam int LSC_REG_CTRL_LSB = 2;

   // The six writable bits held as a 6-bit field, index = register bit - 2
   localparam int LSC_CTL_LIMITER = LSC_REG_LIMITER - LSC_REG_CTRL_LSB;
   localparam int LSC_CTL_TXSEL   = LSC_REG_TXSEL - LSC_REG_CTRL_LSB;
   localparam int LSC_CTL_TONE    = LSC_REG_TONE - LSC_REG_CTRL_LSB;
   localparam int LSC_CTL_BOOST   = LSC_REG_BOOST - LSC_REG_CTRL_LSB;
   localparam int LSC_CTL_LEVEL   = LSC_REG_LEVEL - LSC_REG_CTRL_LSB;
   localparam int LSC_CTL_ENABLE  = LSC_REG_ENABLE - LSC_REG_CTRL_LSB;

   localparam logic [5:0] LSC_CTRL_RESET = 6'h00;
   localparam logic [7:0] LSC_REG_RESET  = 8'h00;

   // Output level code {boost, level}: 00 13.25 V, 01 18 V, 10 14.25 V, 11 19.5 V
   localparam logic [1:0] LSC_LEVEL_OFF = 2'h0;

   // Pulsed limiter timing; off time in ms, retry time is a tenth of it
   localparam int LSC_CLK_HZ       = 10000000;
   localparam int LSC_TOFF_MS      = 900;
   localparam int LSC_TON_DIV      = 10;
   localparam int LSC_TOFF_CYCLES  = LSC_TOFF_MS * (LSC_CLK_HZ / 1000);
   localparam int LSC_TON_CYCLES   = LSC_TOFF_CYCLES / LSC_TON_DIV;

   typedef enum logic [1:0] {
      LSC_LIM_RUN,
      LSC_LIM_OFF,
      LSC_LIM_RETRY
   } lsc_lim_state_t;

   typedef enum logic [2:0] {
      LSC_BUS_IDLE,
      LSC_BUS_ADDR,
      LSC_BUS_ADDR_ACK,
      LSC_BUS_WRITE,
      LSC_BUS_WRITE_ACK,
      LSC_BUS_READ,
      LSC_BUS_READ_ACK
   } lsc_bus_state_t;

endpackage

// [design/lsc_supply_ctrl.sv]
// Two-wire serial slave with one 8-bit control/status register for a dish
// supply controller, plus the control decode and pulsed overload limiter.
// Assumes: bus pins and diagnostic inputs are asynchronous; the bus is
// oversampled on linkClk, which must be at least 8x the bus clock rate;
// the system clock clk runs at 10 MHz; the data pin is open drain.

// Functional notes
// - Start, address byte, acked data bytes, stop
// - Answer address 0001000, pin picks four
// - Address LSB selects write or read
// - One 8-bit register, fixed bit order
// - Writes update only upper six bits
// - All register bits cleared at power-on
// - Enable low disables all power blocks
// - Boost and level pick output voltage
// - Tone forced on or gated by pin
// - Transmit select picks tx or rx output
// - Transmit output carries the gated tone
// - Limiter bit picks pulsed or static limit
// - Read returns writable bits as written
// - Lowest bits read live diagnostic flags
// - Read byte shifted out MSB first
// - Host ack on ninth clock repeats byte
// - Host nack releases line, ends read
// - Lockout ignores bus, clears register
// - Ack every accepted byte on ninth clock
// - Pulsed mode: off time, retry, flag
// - Static mode flag follows current clamp
// - Overtemperature shuts supply, sets flag
module lsc_supply_ctrl
   import lsc_pkg::*;
#(
   parameter int TOFF_CYCLES = LSC_TOFF_CYCLES,
   parameter int TON_CYCLES  = LSC_TON_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       linkClk,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output      logic       sdaOut,
   output      logic       sdaOe,
   input  wire logic [1:0] addrSel,
   input  wire logic       uvloIn,
   input  wire logic       thermalIn,
   input  wire logic       overcurrentIn,
   input  wire logic       toneGateInput,
   output      logic       powerOn,
   output      logic [1:0] levelCode,
   output      logic       toneOn,
   output      logic       receiveSupplyOutput,
   output      logic       transmitSupplyOutput,
   output      logic       transmitToneOn,
   output      logic       staticLimitMode,
   output      logic       overtempFlag,
   output      logic       overloadFlag
);

   // System clock domain state
   typedef struct packed {
      logic [5:0]     ctrl;
      logic           overtemp_flag;
      logic           overload_flag;
      lsc_lim_state_t limState;
      logic [31:0]    limCnt;
      logic           wrSeen;
      logic           stTgl;
      logic [7:0]     stData;
      logic           pwrOn;
      logic [1:0]     level;
      logic           tone;
      logic           rxOn;
      logic           txOn;
      logic           txTone;
      logic           staticLim;
   } lsc_core_state_t;

   // Link clock domain state
   typedef struct packed {
      lsc_bus_state_t busState;
      logic [3:0]     bitCnt;
      logic [7:0]     shift;
      logic [7:0]     tx;
      logic           rw;
      logic           hostAck;
      logic           oe;
      logic           sdaDrv;
      logic           sclPrev;
      logic           sdaPrev;
      logic           sclFilt;
      logic           sdaFilt;
      logic           wrTgl;
      logic [7:0]     wrData;
      logic           stSeen;
      logic [7:0]     readByte;
      logic           ackTgl;
   } lsc_link_state_t;

   lsc_core_state_t c_q;
   lsc_core_state_t c_d;
   lsc_link_state_t l_q;
   lsc_link_state_t l_d;

   logic [5:0] ckSync;
   logic [6:0] lkSync;
   logic       ckUvlo;
   logic       ckThermal;
   logic       ckOvercur;
   logic       ckToneGate;
   logic       ckWrTgl;
   logic       ckAckTgl;
   logic       lkScl;
   logic       lkSda;
   logic       lkUvlo;
   logic [1:0] lkAddrSel;
   logic       lkStTgl;
   logic       lkRst;

   // Every asynchronous input and every cross-domain toggle passes two stages
   lsc_sync #(
      .WIDTH (6)
   ) uCoreSync (
      .clk  (clk),
      .din  ({uvloIn, thermalIn, overcurrentIn, toneGateInput, l_q.wrTgl, l_q.ackTgl}),
      .dout (ckSync)
   );

   lsc_sync #(
      .WIDTH (7)
   ) uLinkSync (
      .clk  (linkClk),
      .din  ({sclIn, sdaIn, uvloIn, addrSel, c_q.stTgl, rst}),
      .dout (lkSync)
   );

   assign {ckUvlo, ckThermal, ckOvercur, ckToneGate, ckWrTgl, ckAckTgl} = ckSync;
   assign {lkScl, lkSda, lkUvlo, lkAddrSel, lkStTgl, lkRst} = lkSync;

   // Core: register, limiter, control decode and status publishing
   always_comb begin
      logic en;
      logic pulsed;
      en     = 1'b0;
      pulsed = 1'b0;
      c_d    = c_q;

      // Written byte arrives by toggle; its data word is held stable by the link
      if (ckWrTgl != c_q.wrSeen) begin
         c_d.wrSeen = ckWrTgl;
         c_d.ctrl   = l_q.wrData[7:LSC_REG_CTRL_LSB];
      end

      en     = c_q.ctrl[LSC_CTL_ENABLE];
      pulsed = ~c_q.ctrl[LSC_CTL_LIMITER];

      // Thermal flag is live; hysteresis lives in the sensor that drives it
      c_d.overtemp_flag = ckThermal;

      // Pulsed limiter: off for the off time, then a clean retry clears the flag
      case (c_q.limState)
         LSC_LIM_RUN: begin
            if (ckOvercur) begin
               c_d.limState = LSC_LIM_OFF;
               c_d.limCnt   = 32'h0;
               c_d.overload_flag      = 1'b1;
            end
         end
         LSC_LIM_OFF: begin
            if (c_q.limCnt == 32'(TOFF_CYCLES - 1)) begin
               c_d.limState = LSC_LIM_RETRY;
               c_d.limCnt   = 32'h0;
            end else begin
               c_d.limCnt = c_q.limCnt + 32'h1;
            end
         end
         LSC_LIM_RETRY: begin
            if (ckOvercur) begin
               c_d.limState = LSC_LIM_OFF;
               c_d.limCnt   = 32'h0;
            end else if (c_q.limCnt == 32'(TON_CYCLES - 1)) begin
               c_d.limState = LSC_LIM_RUN;
               c_d.overload_flag      = 1'b0;
            end else begin
               c_d.limCnt = c_q.limCnt + 32'h1;
            end
         end
         default: begin
            c_d.limState = LSC_LIM_RUN;
         end
      endcase

      // Static clamp: the flag follows the clamp; supply idle: the flag is held clear
      if (!pulsed || !en) begin
         c_d.limState = LSC_LIM_RUN;
         c_d.limCnt   = 32'h0;
         c_d.overload_flag      = en & ckOvercur;
      end

      // Lockout wipes the register and blocks any write that lands meanwhile
      if (ckUvlo) begin
         c_d.ctrl     = LSC_CTRL_RESET;
         c_d.overtemp_flag      = 1'b0;
         c_d.overload_flag      = 1'b0;
         c_d.limState = LSC_LIM_RUN;
         c_d.limCnt   = 32'h0;
      end

      // Power decode; enable low forces every power output off
      c_d.pwrOn     = en & ~c_q.overtemp_flag & (c_q.limState != LSC_LIM_OFF);
      c_d.level     = en ? {c_q.ctrl[LSC_CTL_BOOST], c_q.ctrl[LSC_CTL_LEVEL]}
                         : LSC_LEVEL_OFF;
      c_d.tone      = en & (c_q.ctrl[LSC_CTL_TONE] | ckToneGate);
      c_d.rxOn      = en & ~c_q.ctrl[LSC_CTL_TXSEL];
      c_d.txOn      = en & c_q.ctrl[LSC_CTL_TXSEL];
      c_d.txTone    = en & c_q.ctrl[LSC_CTL_TXSEL]
                    & (c_q.ctrl[LSC_CTL_TONE] | ckToneGate);
      c_d.staticLim = c_q.ctrl[LSC_CTL_LIMITER];

      // Publish a fresh register image each time the link acknowledges the last
      if (ckAckTgl == c_q.stTgl) begin
         c_d.stData = {c_q.ctrl, c_q.overtemp_flag, c_q.overload_flag};
         c_d.stTgl  = ~c_q.stTgl;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         c_q          <= '0;
         c_q.ctrl     <= LSC_CTRL_RESET;
         c_q.stData   <= LSC_REG_RESET;
         c_q.limState <= LSC_LIM_RUN;
      end else begin
         c_q <= c_d;
      end
   end

   // Link: filtered bus lines, start/stop detect and the byte engine
   always_comb begin
      logic sclRise;
      logic sclFall;
      logic start;
      logic stop;
      logic [6:0] myAddr;
      sclRise = 1'b0;
      sclFall = 1'b0;
      start   = 1'b0;
      stop    = 1'b0;
      myAddr  = LSC_ADDR_BASE | {5'h00, lkAddrSel};
      l_d     = l_q;

      // Two matching samples are needed before a filtered level moves
      l_d.sclPrev = lkScl;
      l_d.sdaPrev = lkSda;
      if (lkScl == l_q.sclPrev) begin
         l_d.sclFilt = lkScl;
      end
      if (lkSda == l_q.sdaPrev) begin
         l_d.sdaFilt = lkSda;
      end

      sclRise = l_d.sclFilt & ~l_q.sclFilt;
      sclFall = ~l_d.sclFilt & l_q.sclFilt;
      start   = l_q.sclFilt & l_d.sclFilt & l_q.sdaFilt & ~l_d.sdaFilt;
      stop    = l_q.sclFilt & l_d.sclFilt & ~l_q.sdaFilt & l_d.sdaFilt;

      // Take each new register image and hand the toggle back
      if (lkStTgl != l_q.stSeen) begin
         l_d.stSeen   = lkStTgl;
         l_d.readByte = c_q.stData;
         l_d.ackTgl   = lkStTgl;
      end

      case (l_q.busState)
         LSC_BUS_ADDR: begin
            if (sclRise) begin
               l_d.shift  = {l_q.shift[6:0], l_q.sdaFilt};
               l_d.bitCnt = l_q.bitCnt + 4'h1;
            end else if (sclFall && l_q.bitCnt == LSC_BITS_PER_BYTE) begin
               if (l_q.shift[7:1] == myAddr) begin
                  l_d.rw       = l_q.shift[0];
                  l_d.oe       = 1'b1;
                  l_d.busState = LSC_BUS_ADDR_ACK;
               end else begin
                  l_d.busState = LSC_BUS_IDLE;
               end
            end
         end
         LSC_BUS_ADDR_ACK: begin
            if (sclFall) begin
               l_d.bitCnt = 4'h0;
               if (l_q.rw) begin
                  l_d.tx       = l_q.readByte;
                  l_d.oe       = ~l_q.readByte[7];
                  l_d.busState = LSC_BUS_READ;
               end else begin
                  l_d.oe       = 1'b0;
                  l_d.busState = LSC_BUS_WRITE;
               end
            end
         end
         LSC_BUS_WRITE: begin
            if (sclRise) begin
               l_d.shift  = {l_q.shift[6:0], l_q.sdaFilt};
               l_d.bitCnt = l_q.bitCnt + 4'h1;
            end else if (sclFall && l_q.bitCnt == LSC_BITS_PER_BYTE) begin
               l_d.wrData   = l_q.shift;
               l_d.wrTgl    = ~l_q.wrTgl;
               l_d.oe       = 1'b1;
               l_d.busState = LSC_BUS_WRITE_ACK;
            end
         end
         LSC_BUS_WRITE_ACK: begin
            if (sclFall) begin
               l_d.oe       = 1'b0;
               l_d.bitCnt   = 4'h0;
               l_d.busState = LSC_BUS_WRITE;
            end
         end
         LSC_BUS_READ: begin
            if (sclRise) begin
               l_d.bitCnt = l_q.bitCnt + 4'h1;
            end else if (sclFall) begin
               if (l_q.bitCnt == LSC_BITS_PER_BYTE) begin
                  l_d.oe       = 1'b0;                                  // Host owns the ack slot
                  l_d.busState = LSC_BUS_READ_ACK;
               end else begin
                  l_d.tx = {l_q.tx[6:0], 1'b0};
                  l_d.oe = ~l_q.tx[6];
               end
            end
         end
         LSC_BUS_READ_ACK: begin
            if (sclRise) begin
               l_d.hostAck = ~l_q.sdaFilt;
            end else if (sclFall) begin
               l_d.bitCnt = 4'h0;
               if (l_q.hostAck) begin
                  l_d.tx       = l_q.readByte;
                  l_d.oe       = ~l_q.readByte[7];
                  l_d.busState = LSC_BUS_READ;
               end else begin
                  l_d.oe       = 1'b0;
                  l_d.busState = LSC_BUS_IDLE;
               end
            end
         end
         default: begin
            l_d.oe = 1'b0;                                             // Idle waits for start
         end
      endcase

      // Start and stop override the engine wherever it stands
      if (start) begin
         l_d.busState = LSC_BUS_ADDR;
         l_d.bitCnt   = 4'h0;
         l_d.oe       = 1'b0;
      end else if (stop) begin
         l_d.busState = LSC_BUS_IDLE;
         l_d.bitCnt   = 4'h0;
         l_d.oe       = 1'b0;
      end

      // Under lockout the slave stays deaf and never pulls the line
      if (lkUvlo) begin
         l_d.busState = LSC_BUS_IDLE;
         l_d.oe       = 1'b0;
      end

      // Open drain: the pin is only ever pulled low
      l_d.sdaDrv = 1'b0;
   end

   always_ff @(posedge linkClk) begin
      if (lkRst) begin
         l_q          <= '0;
         l_q.busState <= LSC_BUS_IDLE;
         l_q.sclPrev  <= 1'b1;
         l_q.sdaPrev  <= 1'b1;
         l_q.sclFilt  <= 1'b1;
         l_q.sdaFilt  <= 1'b1;
         l_q.readByte <= LSC_REG_RESET;
      end else begin
         l_q <= l_d;
      end
   end

   // All outputs straight from flip-flops
   assign sdaOut               = l_q.sdaDrv;
   assign sdaOe                = l_q.oe;
   assign powerOn              = c_q.pwrOn;
   assign levelCode            = c_q.level;
   assign toneOn               = c_q.tone;
   assign receiveSupplyOutput  = c_q.rxOn;
   assign transmitSupplyOutput = c_q.txOn;
   assign transmitToneOn       = c_q.txTone;
   assign staticLimitMode      = c_q.staticLim;
   assign overtempFlag         = c_q.overtemp_flag;
   assign overloadFlag         = c_q.overload_flag;

endmodule

// [design/lsc_sync.sv]
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level or a toggle; no reset, so the owner must hold
// its reset for at least three edges of this clock.
module lsc_sync
   import lsc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } lsc_sync_state_t;

   lsc_sync_state_t s_q;
   lsc_sync_state_t s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d        = s_q;
      s_d.stage1 = din;
      s_d.stage2 = s_q.stage1;
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign dout = s_q.stage2;

endmodule

// [tb/lsc_host_model.sv]
// Host bus master model: drives the clock line and pulls the data line.
// Assumes a pull-up on the data line; the device pulls low through sdaOe.
module lsc_host_model (
   input  wire logic clk,
   input  wire logic sdaOe,
   output      logic scl,
   output      logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hostPull = 1'b0;
   initial scl = 1'b1;
   // Open-drain wire: released means pulled high, never a stale value
   assign sda = !(hostPull || sdaOe);

   // Half bit period of 5 system clocks keeps the bus well below the limits
   task automatic half();
      repeat (5) @(negedge clk);
   endtask

   // Data falls while the clock is high
   task automatic bus_start();
      hostPull = 1'b0;
      half();
      scl = 1'b1;
      half();
      hostPull = 1'b1;
      half();
      scl = 1'b0;
   endtask

   // Data rises while the clock is high
   task automatic bus_stop();
      hostPull = 1'b1;
      half();
      scl = 1'b1;
      half();
      hostPull = 1'b0;
      half();
   endtask

   // Nine clocks; a 1 bit releases the line, so reads and acks share it
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         hostPull = !tx[i];
         half();
         scl = 1'b1;
         repeat (3) @(negedge clk);
         rx[i] = sda;
         repeat (2) @(negedge clk);
         scl = 1'b0;
         // Hold data one clock past the fall so it never moves with the clock
         @(negedge clk);
      end
   endtask
endmodule

// [tb/lsc_supply_ctrl_bench.sv]
// Bench for the supply control slave: register traffic through the host
// model, checks on control outputs and read images. No external files.
module lsc_supply_ctrl_bench
   import lsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, rst, linkClk, uvloIn, thermalIn, overcurrentIn, gate;
   logic [1:0] addrSel, levelCode;
   logic       scl, sda, sdaOut, sdaOe, powerOn, toneOn, rxOn, txOn, txTone, stat, overtemp_flag, overload_flag;
   logic [7:0] outs;
   int         errorCnt = 0;
   int         samplesChecked = 0;
   assign outs = {powerOn, levelCode, toneOn, rxOn, txOn, txTone, stat};

   lsc_supply_ctrl #(.TOFF_CYCLES(40), .TON_CYCLES(4)) u_dut (
      .clk(clk), .rst(rst), .linkClk(linkClk), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .addrSel(addrSel), .uvloIn(uvloIn), .thermalIn(thermalIn),
      .overcurrentIn(overcurrentIn), .toneGateInput(gate), .powerOn(powerOn),
      .levelCode(levelCode), .toneOn(toneOn), .receiveSupplyOutput(rxOn),
      .transmitSupplyOutput(txOn), .transmitToneOn(txTone), .staticLimitMode(stat),
      .overtempFlag(overtemp_flag), .overloadFlag(overload_flag));
   lsc_host_model u_host (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sda(sda));

   // Clocks: 100 ns system, 32 ns link with an odd phase offset
   initial begin
      clk = 1'b0;
      forever #50 clk = !clk;
   end
   initial begin
      linkClk = 1'b0;
      #7;
      forever #16 linkClk = !linkClk;
   end

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errorCnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Address byte, optional data byte, stop; settle time lets outputs land
   task automatic wr(input logic [7:0] adr, input logic [7:0] d, input logic ackExp);
      logic [8:0] r;
      u_host.bus_start();
      u_host.xfer({adr, 1'b1}, r);
      chk("addr ack", {7'h0, ackExp}, {7'h0, !r[0]}); // Acked address
      if (ackExp) begin
         u_host.xfer({d, 1'b1}, r);
         chk("data ack", 8'h01, {7'h0, !r[0]}); // Acked data
      end
      u_host.bus_stop();
      repeat (10) @(negedge clk);
   endtask

   // Read n copies, acking all but the last
   task automatic rd(input int n, input logic [7:0] exp);
      logic [8:0] r;
      u_host.bus_start();
      u_host.xfer({8'h11, 1'b1}, r);
      chk("read addr ack", 8'h01, {7'h0, !r[0]}); // Direction bit set
      for (int i = 0; i < n; i++) begin
         u_host.xfer({8'hFF, i == n - 1}, r);
         chk("read data", exp, r[8:1]); // Image MSB first
      end
      // A wrongly repeated byte would pull the line a few link clocks after the fall
      repeat (2) @(negedge clk);
      chk("released", 8'h00, {6'h0, sdaOut, sdaOe}); // Line freed after nack
      u_host.bus_stop();
      repeat (10) @(negedge clk);
   endtask

   // Watchdog sized well past the expected run of about 0.56 ms
   initial begin
      #3000000;
      errorCnt++;
      wrapUp();
   end

   initial begin
      {uvloIn, thermalIn, overcurrentIn, gate} = 4'h0;
      addrSel = 2'h0;
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (12) @(negedge clk);
      rd(1, 8'h00); // Cleared image
      chk("reset outs", 8'h00, outs); // Nothing powered
      wr(8'h10, 8'hFF, 1'b1); // Write all ones
      rd(3, 8'hFC); // Flags ignore writes
      chk("all on", 8'hF7, outs); // Full control decode
      // Every output level code
      for (int i = 0; i < 4; i++) begin
         wr(8'h10, {3'h0, i[1:0], 3'h4}, 1'b1);
         chk("level", {6'h0, i[1:0]}, {6'h0, levelCode}); // Level select
      end
      chk("rx pulsed", 8'hE8, outs); // Receive path, pulsed mode
      gate = 1'b1;
      repeat (10) @(negedge clk);
      chk("gate on", 8'h01, {7'h0, toneOn}); // Pin gates tone
      wr(8'h10, 8'h44, 1'b1);
      chk("tx tone", 8'h96, outs); // Transmit carries tone
      gate = 1'b0;
      repeat (10) @(negedge clk);
      chk("gate off", 8'h00, {7'h0, toneOn}); // Pin gates tone
      wr(8'h10, 8'hF8, 1'b1);
      // Enable low wins; the limiter mode bit is still reported
      chk("disabled", 8'h01, outs);
      rd(1, 8'hF8); // Bit order kept
      // Each address code: neighbour refused, own address accepted
      for (int s = 0; s < 4; s++) begin
         addrSel = s[1:0];
         repeat (10) @(negedge clk);
         wr({LSC_ADDR_BASE | {5'h0, s[1:0] ^ 2'h1}, 1'b0}, 8'hFC, 1'b0); // Foreign
         wr({LSC_ADDR_BASE | {5'h0, s[1:0]}, 1'b0}, 8'h04, 1'b1); // Own address
      end
      addrSel = 2'h0;
      repeat (10) @(negedge clk);
      thermalIn = 1'b1;
      repeat (10) @(negedge clk);
      chk("thermal off", 8'h00, {7'h0, powerOn}); // Shutdown
      rd(1, 8'h06); // Live overtemperature
      thermalIn = 1'b0;
      repeat (10) @(negedge clk);
      chk("thermal back", 8'h01, {7'h0, powerOn}); // Resumes
      wr(8'h10, 8'h84, 1'b1);
      overcurrentIn = 1'b1;
      repeat (10) @(negedge clk);
      rd(1, 8'h85); // Static clamp flag
      overcurrentIn = 1'b0;
      repeat (10) @(negedge clk);
      chk("static clear", 8'h00, {7'h0, overload_flag}); // Follows clamp
      wr(8'h10, 8'h04, 1'b1);
      overcurrentIn = 1'b1;
      repeat (3) @(negedge clk);
      overcurrentIn = 1'b0;
      repeat (6) @(negedge clk);
      chk("pulse off", 8'h80, {overload_flag, 6'h0, powerOn}); // Off time, flag set
      repeat (60) @(negedge clk);
      chk("pulse done", 8'h01, {overload_flag, 6'h0, powerOn}); // Clean retry clears
      uvloIn = 1'b1;
      repeat (10) @(negedge clk);
      wr(8'h10, 8'hFF, 1'b0); // No ack in lockout
      chk("lockout outs", 8'h00, outs); // Register cleared
      uvloIn = 1'b0;
      repeat (10) @(negedge clk);
      rd(1, 8'h00); // Operative again, image zero
      wrapUp();
   end
endmodule

// [tb/lsc_supply_ctrl_props.sv]
// Checker for the supply control slave: relations between its outputs.
// Assumes the clk domain only; bound to every lsc_supply_ctrl instance.
module lsc_supply_ctrl_props (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       sdaOe,
   input wire logic       uvloIn,
   input wire logic       thermalIn,
   input wire logic       overcurrentIn,
   input wire logic       toneGateInput,
   input wire logic       powerOn,
   input wire logic [1:0] levelCode,
   input wire logic       toneOn,
   input wire logic       receiveSupplyOutput,
   input wire logic       transmitSupplyOutput,
   input wire logic       transmitToneOn,
   input wire logic       staticLimitMode,
   input wire logic       overtempFlag,
   input wire logic       overloadFlag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // One of the two supply outputs is on exactly when enable is set
   wire logic en = receiveSupplyOutput | transmitSupplyOutput;

   AST_RESET_CLEAR: assert property (disable iff (1'b0)
      rst |=> !en && !powerOn && !overloadFlag)
      else $error("outputs not cleared by reset");
   AST_TXRX_EXCL: assert property (!(receiveSupplyOutput && transmitSupplyOutput))
      else $error("both supply outputs on");
   AST_TX_TONE: assert property (transmitToneOn |-> transmitSupplyOutput && toneOn)
      else $error("transmit tone without transmit output");
   AST_OFF_DISABLED: assert property (!en |-> !powerOn && levelCode == 2'h0 && !toneOn)
      else $error("power blocks active while disabled");
   AST_TONE_GATE: assert property ((en && toneGateInput) [*6] |-> toneOn)
      else $error("tone gate ignored");
   AST_STATIC_OLF: assert property (
      (en && staticLimitMode && overcurrentIn) [*6] |-> overloadFlag)
      else $error("static overload flag missing");
   AST_PULSE_OFF: assert property (
      $rose(overloadFlag) && !staticLimitMode |=> !powerOn [*8])
      else $error("pulsed limiter did not switch off");
   AST_THERMAL: assert property (thermalIn [*6] |-> overtempFlag && !powerOn)
      else $error("thermal shutdown not reflected");
   AST_UVLO: assert property (uvloIn [*8] |-> !en && !sdaOe)
      else $error("activity during lockout");

   // Main scenarios reached
   cover property (transmitToneOn);
   cover property (overloadFlag && !staticLimitMode);
   cover property (sdaOe && !uvloIn);
endmodule

bind lsc_supply_ctrl lsc_supply_ctrl_props u_props (
   .clk(clk), .rst(rst), .sdaOe(sdaOe), .uvloIn(uvloIn), .thermalIn(thermalIn),
   .overcurrentIn(overcurrentIn), .toneGateInput(toneGateInput), .powerOn(powerOn),
   .levelCode(levelCode), .toneOn(toneOn), .receiveSupplyOutput(receiveSupplyOutput),
   .transmitSupplyOutput(transmitSupplyOutput), .transmitToneOn(transmitToneOn),
   .staticLimitMode(staticLimitMode), .overtempFlag(overtempFlag),
   .overloadFlag(overloadFlag));
